// ===== hw/acl_defines.svh
// constants for the action combiner: offsets, field values, widths
`ifndef ACL_DEFINES_SVH
`define ACL_DEFINES_SVH
// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_MERGES 12'h004
`define OFF_LAST 12'h008
// control fields
`define CTRL_COMBINE_BIT 0
`define CTRL_OUTER_ONLY_BIT 1
`define CTRL_RESET 32'h0000_0001
`define ZERO32 32'h0000_0000
`define ONE32 32'h0000_0001
// last-result field positions
`define LAST_MODE_LSB 0
`define LAST_OVR_FIRST_BIT 4
`define LAST_OVR_SECOND_BIT 5
// field widths
`define W_POL 8
`define W_LOG 4
`define W_MODE 3
`define W_PORTS 12
`define W_MIR 2
`define W_REW 4
`define W_RTM 4
`define W_L4P 16
`define W_TAG 8
`define W_CNT 6
// port-mask mode encodings
`define MODE_KEEP 3'h0
`define MODE_AND 3'h1
`define MODE_OR 3'h2
`define MODE_REPLACE_ALL 3'h3
`define MODE_REDIRECT_TO_GROUP 3'h4
`define MODE_REPLACE 3'h5
`define MODE_STACKING_FORWARD 3'h6
`endif

// ===== hw/acl_pkg.sv
// types shared by the action combiner and its per-action stage
package acl_pkg;
`include "acl_defines.svh"
    typedef struct packed {
        logic inner_point_select;
        logic pipeline_override;
        logic learning_disable;
        logic routing_disable;
        logic policer_enable;
        logic [`W_POL-1:0] policer_index;
        logic [`W_LOG-1:0] log_message_interval;
        logic [`W_MODE-1:0] mask_mode;
        logic [`W_PORTS-1:0] port_mask;
        logic [`W_MIR-1:0] mirror_target_select;
        logic [`W_REW-1:0] rewriter_command;
        logic hop_limit_update;
        logic test_sequence_numbering;
        logic [`W_RTM-1:0] acl_routing_mode;
        logic layer4_rewrite_enable;
        logic [`W_L4P-1:0] l4_src_port;
        logic [`W_L4P-1:0] l4_dst_port;
        logic [`W_TAG-1:0] match_tag;
        logic [`W_TAG-1:0] match_tag_mask;
        logic address_swap_enable;
        logic [`W_CNT-1:0] counter_index;
    } action_t;
    typedef struct packed {
        logic learning_disable;
        logic routing_disable;
        logic policer_enable;
        logic [`W_POL-1:0] policer_index;
        logic [`W_LOG-1:0] log_message_interval;
        logic [`W_MODE-1:0] mask_mode;
        logic [`W_PORTS-1:0] port_mask;
        logic [`W_MIR-1:0] mirror_target_select;
        logic [`W_REW-1:0] rewriter_command;
        logic hop_limit_update;
        logic test_sequence_numbering;
        logic [`W_RTM-1:0] acl_routing_mode;
        logic layer4_rewrite_enable;
        logic [`W_L4P-1:0] l4_src_port;
        logic [`W_L4P-1:0] l4_dst_port;
        logic [`W_TAG-1:0] match_tag;
        logic address_swap_enable;
    } result_t;
endpackage

// ===== hw/acl_step_if.sv
// carrier between the combiner and one action stage
`timescale 1ns/1ps
interface acl_step_if;
    import acl_pkg::*;
    result_t res_in;
    action_t act;
    logic en;
    result_t res_out;
    modport stage (input res_in, input act, input en, output res_out);
    modport host (output res_in, output act, output en, input res_out);
endinterface

// ===== hw/acl_action_apply.sv
// applies one action onto the result built so far
`timescale 1ns/1ps
`include "acl_defines.svh"
module acl_action_apply
    import acl_pkg::*;
(
    acl_step_if.stage st
);
    logic sticky_w;

    // a sticky earlier mode locks mode and mask against later actions
    assign sticky_w = (st.res_in.mask_mode == `MODE_REPLACE_ALL) ||
                      (st.res_in.mask_mode == `MODE_REDIRECT_TO_GROUP) ||
                      (st.res_in.mask_mode == `MODE_STACKING_FORWARD);

    // disabled stage passes the result untouched
    always_comb
    begin
        st.res_out = st.res_in;
        if (st.en)
        begin
            // sticky bits only ever set
            st.res_out.learning_disable = st.res_in.learning_disable | st.act.learning_disable;
            st.res_out.routing_disable = st.res_in.routing_disable | st.act.routing_disable;
            st.res_out.policer_enable = st.res_in.policer_enable | st.act.policer_enable;
            st.res_out.address_swap_enable = st.res_in.address_swap_enable | st.act.address_swap_enable;
            if (st.act.policer_enable)
                st.res_out.policer_index = st.act.policer_index;
            if (st.act.log_message_interval != '0)
                st.res_out.log_message_interval = st.act.log_message_interval;
            if (!sticky_w && st.act.mask_mode != `MODE_KEEP)
            begin
                st.res_out.mask_mode = st.act.mask_mode;
                case (st.act.mask_mode)
                    `MODE_AND: st.res_out.port_mask = st.res_in.port_mask & st.act.port_mask;
                    `MODE_OR: st.res_out.port_mask = st.res_in.port_mask | st.act.port_mask;
                    `MODE_REPLACE_ALL, `MODE_REDIRECT_TO_GROUP, `MODE_REPLACE, `MODE_STACKING_FORWARD:
                        st.res_out.port_mask = st.act.port_mask;
                    default: st.res_out.port_mask = st.res_in.port_mask;
                endcase
            end
            if (st.act.mirror_target_select != '0)
                st.res_out.mirror_target_select = st.act.mirror_target_select;
            // each bit is one function; or-ing keeps distinct ones, same ones merge
            st.res_out.rewriter_command = st.res_in.rewriter_command | st.act.rewriter_command;
            st.res_out.hop_limit_update = st.res_in.hop_limit_update | st.act.hop_limit_update;
            st.res_out.test_sequence_numbering =
                st.res_in.test_sequence_numbering | st.act.test_sequence_numbering;
            st.res_out.acl_routing_mode = st.res_in.acl_routing_mode | st.act.acl_routing_mode;
            if (st.act.layer4_rewrite_enable)
            begin
                st.res_out.layer4_rewrite_enable = 1'b1;
                st.res_out.l4_src_port = st.act.l4_src_port;
                st.res_out.l4_dst_port = st.act.l4_dst_port;
            end
            // masked bits of the tag come from this action, the rest carry over
            st.res_out.match_tag = (st.res_in.match_tag & ~st.act.match_tag_mask) |
                                   (st.act.match_tag & st.act.match_tag_mask);
        end
    end
endmodule

// ===== hw/acl_action_combiner.sv
// combiner of the two lookup actions, with apb control and status
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "acl_defines.svh"
// Summary of operation
// - learning, routing disable and policer enable sticky
// - second policer index only when its policer set
// - pipeline override kept per action, never merged
// - second log interval wins only when nonzero
// - port mask per action; sticky first blocks second
// - modes 3, 4, 6 are sticky
// - second mirror target wins only when nonzero
// - rewriter: same function second wins, different both
// - hop limit, sequence, routing mode: same merge
// - second layer4 ports only when its enable set
// - match tag chained through both actions with masks
// - both processed: two counters incremented, one each
// - non-sticky fields: later processing takes precedence
// - sticky set earlier is never cleared later
// - order: outer first, second; then inner first, second
module acl_action_combiner
    import acl_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic act_valid,
    input wire action_t act_first,
    input wire action_t act_second,
    input wire logic apply_first,
    input wire logic apply_second,
    input wire logic [`W_PORTS-1:0] fwd_mask_in,
    output logic res_valid,
    output result_t res,
    output logic pl_override_first,
    output logic pl_override_second,
    output logic cnt_inc_first,
    output logic [`W_CNT-1:0] cnt_idx_first,
    output logic cnt_inc_second,
    output logic [`W_CNT-1:0] cnt_idx_second
);
    logic [31:0] ctrl_q;
    logic [31:0] merges_q;
    logic [`W_MODE-1:0] last_mode_q;
    logic wr_w;
    logic rd_setup_w;
    logic hit_w;
    logic combine_w;
    logic outer_only_w;
    logic en_first_w;
    logic en_second_w;
    logic swap_w;
    logic take_w;
    result_t start_w;

    acl_step_if step [2] ();

    // zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_w = psel && penable && pwrite;
    assign rd_setup_w = psel && !penable && !pwrite;
    assign hit_w = (paddr == ADDR_W'(`OFF_CTRL)) || (paddr == ADDR_W'(`OFF_MERGES)) ||
                   (paddr == ADDR_W'(`OFF_LAST));
    assign pslverr = psel && penable && !hit_w;

    // control register; unmapped writes are dropped with an error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= `CTRL_RESET;
        else if (wr_w && paddr == ADDR_W'(`OFF_CTRL))
            ctrl_q <= pwdata;
    end

    assign combine_w = ctrl_q[`CTRL_COMBINE_BIT];
    assign outer_only_w = ctrl_q[`CTRL_OUTER_ONLY_BIT];

    // read data is loaded in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= `ZERO32;
        else if (rd_setup_w)
        begin
            if (paddr == ADDR_W'(`OFF_CTRL))
                prdata <= ctrl_q;
            else if (paddr == ADDR_W'(`OFF_MERGES))
                prdata <= merges_q;
            else if (paddr == ADDR_W'(`OFF_LAST))
                prdata <= {26'h0, pl_override_second, pl_override_first, 1'b0, last_mode_q};
            else
                prdata <= `ZERO32;
        end
    end

    // pipeline state may suppress an action; outer_only drops inner ones
    assign en_first_w = apply_first && !(outer_only_w && act_first.inner_point_select);
    assign en_second_w = apply_second && !(outer_only_w && act_second.inner_point_select);
    // only an inner first with an outer second reverses the order
    assign swap_w = act_first.inner_point_select && !act_second.inner_point_select;
    assign take_w = act_valid && combine_w;

    // the forwarding mask entering the combiner seeds the chain
    always_comb
    begin
        start_w = '0;
        start_w.port_mask = fwd_mask_in;
    end

    // stage 0 runs the earlier action, stage 1 the later on its result
    assign step[0].res_in = start_w;
    assign step[0].act = swap_w ? act_second : act_first;
    assign step[0].en = swap_w ? en_second_w : en_first_w;
    assign step[1].res_in = step[0].res_out;
    assign step[1].act = swap_w ? act_first : act_second;
    assign step[1].en = swap_w ? en_first_w : en_second_w;

    for (genvar i = 0; i < 2; i++)
    begin : g_stage
        acl_action_apply u_apply (
            .st(step[i])
        );
    end

    // merged result and valid pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res <= '0;
            res_valid <= 1'b0;
        end
        else
        begin
            res_valid <= take_w;
            if (take_w)
                res <= step[1].res_out;
        end
    end

    // override flags are reported per action without merging
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pl_override_first <= 1'b0;
            pl_override_second <= 1'b0;
        end
        else if (take_w)
        begin
            pl_override_first <= act_first.pipeline_override;
            pl_override_second <= act_second.pipeline_override;
        end
    end

    // one statistics counter bump per processed action
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_inc_first <= 1'b0;
            cnt_inc_second <= 1'b0;
            cnt_idx_first <= '0;
            cnt_idx_second <= '0;
        end
        else
        begin
            cnt_inc_first <= take_w && en_first_w;
            cnt_inc_second <= take_w && en_second_w;
            if (take_w)
            begin
                cnt_idx_first <= act_first.counter_index;
                cnt_idx_second <= act_second.counter_index;
            end
        end
    end

    // status: merge count (a write clears it, a merge in that cycle is counted after the clear, giving one) and last mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            merges_q <= `ZERO32;
            last_mode_q <= '0;
        end
        else
        begin
            if (take_w && wr_w && paddr == ADDR_W'(`OFF_MERGES))
                merges_q <= `ONE32;
            else if (take_w)
                merges_q <= merges_q + `ONE32;
            else if (wr_w && paddr == ADDR_W'(`OFF_MERGES))
                merges_q <= `ZERO32;
            if (take_w)
                last_mode_q <= step[1].res_out.mask_mode;
        end
    end

    // checks on the merge, both actions outer unless stated
    logic both_outer_w;
    assign both_outer_w = !act_first.inner_point_select && !act_second.inner_point_select;

    sticky_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
        take_w && en_first_w && act_first.learning_disable |=> res_valid && res.learning_disable)
        else $error("learning disable was cleared");

    policer_idx_a: assert property (@(posedge pclk) disable iff (!presetn)
        take_w && en_first_w && en_second_w && both_outer_w && !act_second.policer_enable
        && act_first.policer_enable |=> res.policer_index == $past(act_first.policer_index))
        else $error("policer index replaced without enable");

    override_a: assert property (@(posedge pclk) disable iff (!presetn)
        take_w |=> pl_override_first == $past(act_first.pipeline_override)
        && pl_override_second == $past(act_second.pipeline_override))
        else $error("override flags merged");

    log_int_a: assert property (@(posedge pclk) disable iff (!presetn)
        take_w && en_first_w && en_second_w && both_outer_w && act_second.log_message_interval == '0
        |=> res.log_message_interval == $past(act_first.log_message_interval))
        else $error("zero log interval overrode first");

    mask_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        take_w && en_first_w && both_outer_w && act_first.mask_mode == `MODE_STACKING_FORWARD
        |=> res.mask_mode == `MODE_STACKING_FORWARD && res.port_mask == $past(act_first.port_mask))
        else $error("sticky mask mode overwritten");

    mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
        take_w && en_second_w && act_second.mirror_target_select != '0
        && !(swap_w && en_first_w && act_first.mirror_target_select != '0)
        |=> res.mirror_target_select == $past(act_second.mirror_target_select))
        else $error("nonzero mirror target not taken");

    layer4_a: assert property (@(posedge pclk) disable iff (!presetn)
        take_w && en_first_w && en_second_w && both_outer_w && act_second.layer4_rewrite_enable
        |=> res.l4_dst_port == $past(act_second.l4_dst_port))
        else $error("layer4 ports not replaced");

    counters_a: assert property (@(posedge pclk) disable iff (!presetn)
        take_w && en_first_w && en_second_w |=> cnt_inc_first && cnt_inc_second
        ##1 !cnt_inc_first || $past(take_w))
        else $error("two counters not bumped");

    order_a: assert property (@(posedge pclk) disable iff (!presetn)
        take_w && en_first_w && en_second_w && swap_w && act_first.log_message_interval != '0
        |=> res.log_message_interval == $past(act_first.log_message_interval))
        else $error("inner first action not processed last");

    suppress_a: assert property (@(posedge pclk) disable iff (!presetn)
        take_w && en_first_w && !en_second_w
        |=> res.mirror_target_select == $past(act_first.mirror_target_select)
        && !cnt_inc_second)
        else $error("suppressed action leaked into result");

    both_cover_c: cover property (@(posedge pclk) disable iff (!presetn)
        take_w && en_first_w && en_second_w ##1 res_valid);
    swap_cover_c: cover property (@(posedge pclk) disable iff (!presetn)
        take_w && swap_w && en_first_w && en_second_w);
    sticky_cover_c: cover property (@(posedge pclk) disable iff (!presetn)
        take_w && en_first_w && act_first.mask_mode == `MODE_REDIRECT_TO_GROUP && en_second_w);
endmodule

// ===== bench/acl_lookup_model.sv
// lookup engine model that presents action pairs to the combiner
`timescale 1ns/1ps
`include "acl_defines.svh"
module acl_lookup_model
    import acl_pkg::*;
(
    input wire logic pclk,
    output logic act_valid,
    output action_t act_first,
    output action_t act_second,
    output logic apply_first,
    output logic apply_second,
    output logic [`W_PORTS-1:0] fwd_mask_in
);
    initial
    begin
        act_valid = 1'b0;
        act_first = '0;
        act_second = '0;
        apply_first = 1'b0;
        apply_second = 1'b0;
        fwd_mask_in = '0;
    end
    // released lines drop valid and show the inverse of the others so stale data never looks valid
    task automatic release_lines();
        act_valid <= 1'b0;
        act_first <= ~act_first;
        act_second <= ~act_second;
        apply_first <= ~apply_first;
        apply_second <= ~apply_second;
        fwd_mask_in <= ~fwd_mask_in;
    endtask
    // gap of zero keeps valid up for back-to-back pairs
    task automatic send(input action_t f, input action_t s, input logic af, input logic as_,
        input logic [`W_PORTS-1:0] fm, input int gap);
        if (gap > 0)
        begin
            release_lines();
            repeat (gap) @(posedge pclk);
        end
        act_valid <= 1'b1;
        act_first <= f;
        act_second <= s;
        apply_first <= af;
        apply_second <= as_;
        fwd_mask_in <= fm;
        @(posedge pclk);
    endtask
    task automatic idle();
        release_lines();
        @(posedge pclk);
    endtask
endmodule

// ===== bench/acl_action_combiner_test.sv
// self-checking bench for the action combiner with a reference merge model
`timescale 1ns/1ps
`include "acl_defines.svh"
module acl_action_combiner_test
    import acl_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, res_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ctrl_m, last_m, lfsr, rd, w;
    logic act_valid, apply_first, apply_second, pl_override_first, pl_override_second;
    logic cnt_inc_first, cnt_inc_second, pend, ef, es, of_, os, uf, us, e;
    logic [`W_PORTS-1:0] fwd_mask_in;
    logic [`W_CNT-1:0] cnt_idx_first, cnt_idx_second, xf, xs;
    action_t act_first, act_second, f, s;
    result_t res, exp_r;
    int err_count, num_checks, merges_m, i, j;

    acl_action_combiner u_acl_action_combiner (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .act_valid(act_valid), .act_first(act_first),
        .act_second(act_second), .apply_first(apply_first), .apply_second(apply_second),
        .fwd_mask_in(fwd_mask_in), .res_valid(res_valid), .res(res),
        .pl_override_first(pl_override_first), .pl_override_second(pl_override_second),
        .cnt_inc_first(cnt_inc_first), .cnt_idx_first(cnt_idx_first),
        .cnt_inc_second(cnt_inc_second), .cnt_idx_second(cnt_idx_second));
    acl_lookup_model u_acl_lookup_model (.pclk(pclk), .act_valid(act_valid), .act_first(act_first),
        .act_second(act_second), .apply_first(apply_first), .apply_second(apply_second),
        .fwd_mask_in(fwd_mask_in));

    // 250 MHz core clock
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function logic [31:0] rnd();
        lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'h8020_0003 : lfsr >> 1;
        return lfsr;
    endfunction

    function action_t ract();
        logic [127:0] v;
        v = {rnd(), rnd(), rnd(), rnd()};
        return action_t'(v[$bits(action_t)-1:0]);
    endfunction

    // one action onto the result so far, per field policy
    function automatic result_t step(result_t r, action_t a);
        r.learning_disable |= a.learning_disable;
        r.routing_disable |= a.routing_disable;
        r.policer_enable |= a.policer_enable;
        if (a.policer_enable) r.policer_index = a.policer_index;
        if (a.log_message_interval != 0) r.log_message_interval = a.log_message_interval;
        if (a.mask_mode != `MODE_KEEP &&
            !(r.mask_mode inside {`MODE_REPLACE_ALL, `MODE_REDIRECT_TO_GROUP, `MODE_STACKING_FORWARD}))
        begin
            r.mask_mode = a.mask_mode;
            case (a.mask_mode)
                `MODE_AND: r.port_mask &= a.port_mask;
                `MODE_OR: r.port_mask |= a.port_mask;
                `MODE_REPLACE_ALL, `MODE_REDIRECT_TO_GROUP, `MODE_REPLACE, `MODE_STACKING_FORWARD:
                    r.port_mask = a.port_mask;
                default: ;
            endcase
        end
        if (a.mirror_target_select != 0) r.mirror_target_select = a.mirror_target_select;
        r.rewriter_command |= a.rewriter_command;
        r.hop_limit_update |= a.hop_limit_update;
        r.test_sequence_numbering |= a.test_sequence_numbering;
        r.acl_routing_mode |= a.acl_routing_mode;
        if (a.layer4_rewrite_enable)
        begin
            r.layer4_rewrite_enable = 1'b1;
            r.l4_src_port = a.l4_src_port;
            r.l4_dst_port = a.l4_dst_port;
        end
        r.match_tag = (r.match_tag & ~a.match_tag_mask) | (a.match_tag & a.match_tag_mask);
        r.address_swap_enable |= a.address_swap_enable;
        return r;
    endfunction

    function automatic result_t merge(action_t fa, action_t sa, logic ufa, logic usa, logic [`W_PORTS-1:0] fm);
        result_t r;
        r = '0;
        r.port_mask = fm;
        if (fa.inner_point_select && !sa.inner_point_select)
        begin
            if (usa) r = step(r, sa);
            if (ufa) r = step(r, fa);
        end
        else
        begin
            if (ufa) r = step(r, fa);
            if (usa) r = step(r, sa);
        end
        return r;
    endfunction

    // scoreboard: predict at the accepting edge, compare one edge later
    always @(posedge pclk)
    begin
        if (presetn === 1'b1)
        begin
            check(res_valid, pend, "result pulse");
            if (pend)
            begin
                check(res, exp_r, "merged result");
                check({cnt_inc_first, cnt_inc_second}, {ef, es}, "counter pulses");
                if (ef) check(cnt_idx_first, xf, "first counter index");
                if (es) check(cnt_idx_second, xs, "second counter index");
                check({pl_override_first, pl_override_second}, {of_, os}, "overrides");
            end
            pend = act_valid && ctrl_m[`CTRL_COMBINE_BIT];
            if (pend)
            begin
                uf = apply_first && !(ctrl_m[`CTRL_OUTER_ONLY_BIT] && act_first.inner_point_select);
                us = apply_second && !(ctrl_m[`CTRL_OUTER_ONLY_BIT] && act_second.inner_point_select);
                exp_r = merge(act_first, act_second, uf, us, fwd_mask_in);
                {ef, es, xf, xs} = {uf, us, act_first.counter_index, act_second.counter_index};
                {of_, os} = {act_first.pipeline_override, act_second.pipeline_override};
                last_m = `ZERO32;
                last_m[`LAST_MODE_LSB+:`W_MODE] = exp_r.mask_mode;
                last_m[`LAST_OVR_FIRST_BIT] = of_;
                last_m[`LAST_OVR_SECOND_BIT] = os;
                merges_m++;
            end
        end
        else
            pend = 1'b0;
    end

    // apb master: request held until pready seen high; caller releases or chains
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rdat, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            check(0, 1, "pready wait");
            summarize();
        end
        rdat = prdata;
        err = pslverr;
        if (wr && a == `OFF_CTRL) ctrl_m = d;
        if (wr && a == `OFF_MERGES) merges_m = 0;
    endtask

    task automatic apb_idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // hang guard
    initial
    begin
        repeat (40000) @(posedge pclk);
        check(0, 1, "run time limit");
        summarize();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {err_count, num_checks, merges_m} = '0;
        ctrl_m = `CTRL_RESET;
        lfsr = 32'h0000_0058;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, unmapped access, back-to-back reads
        apb(0, `OFF_CTRL, `ZERO32, rd, e);
        check(rd, `CTRL_RESET, "ctrl reset");
        apb(0, `OFF_MERGES, `ZERO32, rd, e);
        check(rd, `ZERO32, "merges reset");
        apb(1, 12'h00C, 32'hFFFF_FFFF, rd, e);
        check(e, 1'b1, "unmapped write error");
        apb(0, 12'h00C, `ZERO32, rd, e);
        check({e, rd}, {1'b1, `ZERO32}, "unmapped read");
        apb_idle();
        // first sets sticky and valued fields, second tries to clear them
        f = ract();
        s = ract();
        {f.inner_point_select, s.inner_point_select} = 2'b00;
        {f.learning_disable, f.routing_disable, f.policer_enable} = 3'b111;
        {s.learning_disable, s.routing_disable, s.policer_enable} = 3'b000;
        s.log_message_interval = '0;
        s.mirror_target_select = '0;
        f.log_message_interval = 4'h5;
        f.mirror_target_select = 2'h2;
        u_acl_lookup_model.send(f, s, 1'b1, 1'b1, `W_PORTS'(rnd()), 0);
        u_acl_lookup_model.idle();
        check({res.learning_disable, res.routing_disable, res.policer_enable}, 3'b111, "sticky");
        check(res.policer_index, f.policer_index, "policer index kept");
        check({res.log_message_interval, res.mirror_target_select}, {4'h5, 2'h2}, "zero kept");
        // every pair of mask modes, back to back
        for (i = 0; i < 8; i++)
            for (j = 0; j < 8; j++)
            begin
                f = ract();
                s = ract();
                {f.mask_mode, s.mask_mode} = {i[2:0], j[2:0]};
                u_acl_lookup_model.send(f, s, 1'b1, 1'b1, `W_PORTS'(rnd()), 0);
            end
        // random pairs, random suppression, prompt and slow presentation
        for (i = 0; i < 60; i++)
        begin
            f = ract();
            s = ract();
            w = rnd();
            u_acl_lookup_model.send(f, s, w[1:0] != 0, w[3:2] != 0, w[15:4], w[17:16] == 0 ? w[19:18] : 0);
        end
        u_acl_lookup_model.idle();
        // combine disabled refuses pairs, then outer-only drops inner actions
        for (j = 0; j < 2; j++)
        begin
            apb(1, `OFF_CTRL, j == 0 ? `ZERO32 : 32'h0000_0003, rd, e);
            apb_idle();
            for (i = 0; i < 20; i++)
                u_acl_lookup_model.send(ract(), ract(), 1'b1, rnd() % 4 != 0, `W_PORTS'(rnd()), 0);
            u_acl_lookup_model.idle();
        end
        apb(1, `OFF_CTRL, `CTRL_RESET, rd, e);
        apb(0, `OFF_MERGES, `ZERO32, rd, e);
        check(rd, merges_m, "merge count");
        apb(0, `OFF_LAST, `ZERO32, rd, e);
        check(rd, last_m, "last result");
        apb(1, `OFF_MERGES, `ZERO32, rd, e);
        apb(0, `OFF_MERGES, `ZERO32, rd, e);
        check(rd, `ZERO32, "merge count cleared");
        apb_idle();
        summarize();
    end
endmodule
